//--- lsal_cfg.svh
`ifndef LSAL_CFG_SVH
`define LSAL_CFG_SVH
// ****************************************
// register offsets
// ****************************************
`define LSAL_ADDR_CFG 8'h40
`define LSAL_ADDR_ST_LO 8'h41
`define LSAL_ADDR_ST_HI 8'h42
`define LSAL_ADDR_TLIM_FIRST 8'h44
`define LSAL_ADDR_TLIM_LAST 8'h57
`define LSAL_ADDR_FMIN_FIRST 8'h58
`define LSAL_ADDR_FMIN_LAST 8'h5f
`define LSAL_ADDR_FMAX_FIRST 8'h60
`define LSAL_ADDR_FMAX_LAST 8'h67
`define LSAL_ADDR_MASK_LO 8'h72
`define LSAL_ADDR_MASK_HI 8'h73
// ****************************************
// field positions and reset values
// ****************************************
`define LSAL_BIT_GO 0
`define LSAL_BIT_SUMMARY 7
`define LSAL_BIT_BELOW 3
`define LSAL_RST_TLO 8'h81
`define LSAL_RST_THI 8'h7f
`define LSAL_RST_FMIN 16'hffff
`define LSAL_RST_FMAX 16'h0000
`define LSAL_RST_CFG 8'h00
`define LSAL_RST_MASK 8'h00
`endif

//--- lsal_pkg.sv
package lsal_pkg;
    // round-robin sequencer states
    typedef enum logic [1:0] {
        lsal_idle = 2'b00, // monitoring stopped
        lsal_req = 2'b01, // ask for a measurement
        lsal_wait = 2'b10 // wait for the result
    } lsal_seq_t;
    // register access from the serial bus engine
    typedef struct packed {
        logic rd; // one-cycle read strobe
        logic wr; // one-cycle write strobe
        logic [7:0] addr; // register offset
        logic [7:0] wdata; // write byte
    } lsal_reg_req_t;
    // one finished measurement
    typedef struct packed {
        logic valid; // one-cycle result strobe
        logic [15:0] value; // temp in [7:0] or tach period
    } lsal_meas_t;
endpackage

//--- lsal_limit_cmp.sv
`timescale 1ns/100ps
// ****************************************
// one channel against its two limits
// ****************************************
module lsal_limit_cmp (
    input wire logic is_temp_i, // channel is a temperature
    input wire logic [15:0] value_i, // measured value
    input wire logic [15:0] lo_i, // low limit or tach min
    input wire logic [15:0] hi_i, // high limit or tach max
    output logic fault_o // value out of range
);
    logic signed [7:0] t_val; // signed temperature
    logic signed [7:0] t_lo; // signed low limit
    logic signed [7:0] t_hi; // signed high limit
    assign t_val = $signed(value_i[7:0]);
    assign t_lo = $signed(lo_i[7:0]);
    assign t_hi = $signed(hi_i[7:0]);
    // temp high is strict, temp low includes equality, tach both strict; a long tach
    // period means a slow fan, a short one overspeed
    always_comb begin
        if (is_temp_i) begin
            fault_o = (t_val > t_hi) || (t_val <= t_lo);
        end else begin
            fault_o = (value_i > lo_i) || (value_i < hi_i);
        end
    end
endmodule

//--- lsal_sticky_bit.sv
`timescale 1ns/100ps
// ****************************************
// one sticky status flag
// ****************************************
module lsal_sticky_bit (
    input wire logic clock_i, // system clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic set_i, // fault seen this cycle
    input wire logic cond_i, // fault still present
    input wire logic rd_clr_i, // owning register read
    output logic flag_o // sticky flag
);
    logic flag_q; // flag state
    // set beats the read-clear so no event is lost
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_q <= 1'b0;
        end else if (set_i) begin
            flag_q <= 1'b1;
        end else if (rd_clr_i && !cond_i) begin
            flag_q <= 1'b0;
        end
    end
    assign flag_o = flag_q;
endmodule

//--- lsal_top.sv
`timescale 1ns/100ps
`include "lsal_cfg.svh"
// How it works
// - measure channels round-robin, then compare
// - high fault only when strictly above
// - temp low fault when at or below; tach strict
// - out of range sets status bit
// - status bits stay set until read
// - read clears only bits whose fault left
// - summary bit shows any second-register bit
// - mask stops alert, status still sets
// - summary and below-minimum never alert
// - alert low while unmasked source flagged
// - alert has no disable beyond masks
// - compare only while monitor_go is set
// - first status bits 0-6 temps 1-7
// - second status bits 4-7 fans 1-4
// - second status bits 0-2 temps 8-10
// - bit 3 flags below zone minimum
// - first mask bits 0-6 temps 1-7
// - second mask fans 4-7, temps 0-2
// - temperatures compare as signed bytes
// - long tach period slow, short overspeed
// - temp limits reset to 0x81, 0x7f
module lsal_top (
    input wire logic clock_i, // 125 MHz system clock
    input wire logic rst_n_i, // async reset, active low
    input wire lsal_pkg::lsal_reg_req_t reg_req_i, // reg access
    output logic [7:0] reg_rdata_o, // read data, registered
    output logic meas_req_o, // start next measurement
    output logic [3:0] meas_chan_o, // channel to measure
    input wire lsal_pkg::lsal_meas_t meas_i, // result
    input wire logic below_tmin_i, // temps below zone min
    output logic monitor_go_o, // monitoring enabled
    output logic alert_o, // alert pin level
    output logic alert_oe_o // alert pin pulled low
);
    // ****************************************
    // constants and state
    // ****************************************
    localparam int NTEMP = 10; // temperature channels
    localparam int NFAN = 4; // fan tach channels
    localparam int NCH = NTEMP + NFAN; // channels in the ring
    localparam int NST = NCH + 1; // sticky flags incl. below
    localparam logic [3:0] LAST_CH = 4'(NCH - 1); // wrap point
    logic [7:0] cfg_q; // config register, bit 0 go
    logic [6:0] mask_lo_q; // first mask register
    logic [7:0] mask_hi_q; // second mask register
    logic [7:0] tlo_q [NTEMP]; // temp low limits
    logic [7:0] thi_q [NTEMP]; // temp high limits
    logic [15:0] fmin_q [NFAN]; // tach min-speed limits
    logic [15:0] fmax_q [NFAN]; // tach max-speed limits
    logic [NCH-1:0] cond_q; // latest comparison results
    logic [NST-1:0] stick; // sticky flags
    logic [NST-1:0] set_v; // set pulses per flag
    logic [NST-1:0] cond_v; // live fault per flag
    logic [NST-1:0] clr_v; // read-clear per flag
    logic [NST-1:0] mask_v; // mask aligned with flags
    lsal_pkg::lsal_seq_t seq_q; // sequencer state
    logic [3:0] chan_q; // channel being measured
    logic [7:0] rdata_q; // read data register
    logic alert_q; // alert drive
    logic go; // monitor_go bit
    logic upd; // result accepted this cycle
    logic is_temp; // current channel is temp
    logic [15:0] lim_lo; // selected low or min limit
    logic [15:0] lim_hi; // selected high or max limit
    logic fault; // comparator result
    logic [7:0] st_lo; // first status register view
    logic [7:0] st_hi; // second status register view
    logic rd_lo; // read of first status register
    logic rd_hi; // read of second status register
    logic [7:0] rd_mux; // combinational read value
    logic [7:0] ta_off; // offset into temp limits
    logic [7:0] fn_off; // offset into min limits
    logic [7:0] fx_off; // offset into max limits
    logic [3:0] tmp_idx; // current temp index
    logic [1:0] fan_idx; // current fan index

    assign go = cfg_q[`LSAL_BIT_GO];
    assign monitor_go_o = go;
    assign ta_off = reg_req_i.addr - `LSAL_ADDR_TLIM_FIRST;
    assign fn_off = reg_req_i.addr - `LSAL_ADDR_FMIN_FIRST;
    assign fx_off = reg_req_i.addr - `LSAL_ADDR_FMAX_FIRST;

    // ****************************************
    // register writes
    // ****************************************
    // config and masks; the alert pin itself has no enable
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_q <= `LSAL_RST_CFG;
            mask_lo_q <= 7'h00;
            mask_hi_q <= `LSAL_RST_MASK;
        end else if (reg_req_i.wr) begin
            if (reg_req_i.addr == `LSAL_ADDR_CFG) begin
                cfg_q <= reg_req_i.wdata;
            end else if (reg_req_i.addr == `LSAL_ADDR_MASK_LO) begin
                mask_lo_q <= reg_req_i.wdata[6:0];
            end else if (reg_req_i.addr == `LSAL_ADDR_MASK_HI) begin
                mask_hi_q <= reg_req_i.wdata & 8'hf7;
            end
        end
    end

    // limit registers; tach limits are written a byte at a
    // time, low byte at the even offset
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NTEMP; i++) begin
                tlo_q[i] <= `LSAL_RST_TLO;
                thi_q[i] <= `LSAL_RST_THI;
            end
            for (int i = 0; i < NFAN; i++) begin
                fmin_q[i] <= `LSAL_RST_FMIN;
                fmax_q[i] <= `LSAL_RST_FMAX;
            end
        end else if (reg_req_i.wr) begin
            if (reg_req_i.addr >= `LSAL_ADDR_TLIM_FIRST &&
                reg_req_i.addr <= `LSAL_ADDR_TLIM_LAST) begin
                if (ta_off[0]) begin
                    thi_q[ta_off[4:1]] <= reg_req_i.wdata;
                end else begin
                    tlo_q[ta_off[4:1]] <= reg_req_i.wdata;
                end
            end else if (reg_req_i.addr >= `LSAL_ADDR_FMIN_FIRST &&
                         reg_req_i.addr <= `LSAL_ADDR_FMIN_LAST) begin
                if (fn_off[0]) begin
                    fmin_q[fn_off[2:1]][15:8] <= reg_req_i.wdata;
                end else begin
                    fmin_q[fn_off[2:1]][7:0] <= reg_req_i.wdata;
                end
            end else if (reg_req_i.addr >= `LSAL_ADDR_FMAX_FIRST &&
                         reg_req_i.addr <= `LSAL_ADDR_FMAX_LAST) begin
                if (fx_off[0]) begin
                    fmax_q[fx_off[2:1]][15:8] <= reg_req_i.wdata;
                end else begin
                    fmax_q[fx_off[2:1]][7:0] <= reg_req_i.wdata;
                end
            end
        end
    end

    // ****************************************
    // round-robin sequencer
    // ****************************************
    // a drop of monitor_go abandons the pending result
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seq_q <= lsal_pkg::lsal_idle;
            chan_q <= 4'h0;
        end else begin
            case (seq_q)
                lsal_pkg::lsal_idle: begin
                    if (go) begin
                        seq_q <= lsal_pkg::lsal_req;
                    end
                end
                lsal_pkg::lsal_req: begin
                    seq_q <= go ? lsal_pkg::lsal_wait
                                : lsal_pkg::lsal_idle;
                end
                lsal_pkg::lsal_wait: begin
                    if (!go) begin
                        seq_q <= lsal_pkg::lsal_idle;
                    end else if (meas_i.valid) begin
                        seq_q <= lsal_pkg::lsal_req;
                        chan_q <= (chan_q == LAST_CH) ? 4'h0
                                  : chan_q + 4'h1;
                    end
                end
                default: begin
                    seq_q <= lsal_pkg::lsal_idle;
                end
            endcase
        end
    end

    assign meas_req_o = (seq_q == lsal_pkg::lsal_req) && go;
    assign meas_chan_o = chan_q;
    assign upd = (seq_q == lsal_pkg::lsal_wait) && go
                 && meas_i.valid;

    // ****************************************
    // limit comparison
    // ****************************************
    assign is_temp = chan_q < 4'(NTEMP);
    assign tmp_idx = is_temp ? chan_q : 4'h0;
    assign fan_idx = is_temp ? 2'h0 : 2'(chan_q - 4'(NTEMP));
    assign lim_lo = is_temp ? {8'h00, tlo_q[tmp_idx]}
                            : fmin_q[fan_idx];
    assign lim_hi = is_temp ? {8'h00, thi_q[tmp_idx]}
                            : fmax_q[fan_idx];

    lsal_limit_cmp u_cmp (
        .is_temp_i(is_temp),
        .value_i(meas_i.value),
        .lo_i(lim_lo),
        .hi_i(lim_hi),
        .fault_o(fault)
    );

    // latest result per channel, used by the read-clear
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cond_q <= '0;
        end else if (upd) begin
            cond_q[chan_q] <= fault;
        end
    end

    // ****************************************
    // sticky status flags
    // ****************************************
    // flag order: temps 1-10, fans 1-4, then below-minimum
    assign rd_lo = reg_req_i.rd &&
                   (reg_req_i.addr == `LSAL_ADDR_ST_LO);
    assign rd_hi = reg_req_i.rd &&
                   (reg_req_i.addr == `LSAL_ADDR_ST_HI);
    genvar g;
    generate
        for (g = 0; g < NST; g++) begin : g_flag
            if (g < NCH) begin : g_ch
                assign set_v[g] = upd && fault
                                  && (chan_q == 4'(g));
                assign cond_v[g] = cond_q[g];
            end else begin : g_below
                assign set_v[g] = go && below_tmin_i;
                assign cond_v[g] = below_tmin_i;
            end
            assign clr_v[g] = (g < 7) ? rd_lo : rd_hi;
            lsal_sticky_bit u_flag (
                .clock_i(clock_i),
                .rst_n_i(rst_n_i),
                .set_i(set_v[g]),
                .cond_i(cond_v[g]),
                .rd_clr_i(clr_v[g]),
                .flag_o(stick[g])
            );
        end
    endgenerate

    // register views of the flags
    assign st_hi = {stick[13:10], stick[14], stick[9:7]};
    assign st_lo = {|st_hi, stick[6:0]};

    // ****************************************
    // register reads
    // ****************************************
    always_comb begin
        rd_mux = 8'h00; // unmapped offsets read zero
        if (reg_req_i.addr == `LSAL_ADDR_CFG) begin
            rd_mux = cfg_q;
        end else if (reg_req_i.addr == `LSAL_ADDR_ST_LO) begin
            rd_mux = st_lo;
        end else if (reg_req_i.addr == `LSAL_ADDR_ST_HI) begin
            rd_mux = st_hi;
        end else if (reg_req_i.addr >= `LSAL_ADDR_TLIM_FIRST &&
                     reg_req_i.addr <= `LSAL_ADDR_TLIM_LAST) begin
            rd_mux = ta_off[0] ? thi_q[ta_off[4:1]]
                               : tlo_q[ta_off[4:1]];
        end else if (reg_req_i.addr >= `LSAL_ADDR_FMIN_FIRST &&
                     reg_req_i.addr <= `LSAL_ADDR_FMIN_LAST) begin
            rd_mux = fn_off[0] ? fmin_q[fn_off[2:1]][15:8]
                               : fmin_q[fn_off[2:1]][7:0];
        end else if (reg_req_i.addr >= `LSAL_ADDR_FMAX_FIRST &&
                     reg_req_i.addr <= `LSAL_ADDR_FMAX_LAST) begin
            rd_mux = fx_off[0] ? fmax_q[fx_off[2:1]][15:8]
                               : fmax_q[fx_off[2:1]][7:0];
        end else if (reg_req_i.addr == `LSAL_ADDR_MASK_LO) begin
            rd_mux = {1'b0, mask_lo_q};
        end else if (reg_req_i.addr == `LSAL_ADDR_MASK_HI) begin
            rd_mux = mask_hi_q;
        end
    end

    // data is latched on the same edge that clears flags,
    // so the host sees the value from before the clear
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 8'h00;
        end else if (reg_req_i.rd) begin
            rdata_q <= rd_mux;
        end
    end
    assign reg_rdata_o = rdata_q;

    // ****************************************
    // alert pin
    // ****************************************
    // below-minimum is forced masked; the summary is not a flag
    assign mask_v = {1'b1, mask_hi_q[7:4], mask_hi_q[2:0],
                     mask_lo_q};
    // registered so the open-drain enable never glitches
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            alert_q <= 1'b0;
        end else begin
            alert_q <= |(stick & ~mask_v);
        end
    end
    assign alert_o = 1'b0; // open drain only pulls low
    assign alert_oe_o = alert_q;

    // ****************************************
    // checks
    // ****************************************
    sequence unmasked_s;
        (|(stick & ~mask_v)) [*2];
    endsequence
    sequence quiet_s;
        (!(|(stick & ~mask_v))) [*2];
    endsequence
    sequence rd_lo_s;
        rd_lo ##1 1'b1;
    endsequence

    go_gate_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        !go |-> !upd && !meas_req_o)
        else $error("result taken while monitoring is off");
    hi_strict_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        upd && is_temp && meas_i.value[7:0] == lim_hi[7:0]
        && $signed(meas_i.value[7:0]) > $signed(lim_lo[7:0])
        |-> !fault)
        else $error("value equal to high limit flagged");
    lo_equal_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        upd && is_temp && meas_i.value[7:0] == lim_lo[7:0]
        |=> stick[$past(chan_q)])
        else $error("value equal to low limit not flagged");
    sticky_hold_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        !rd_lo |=> (stick[6:0] & $past(stick[6:0]))
        == $past(stick[6:0]))
        else $error("first status bit dropped without read");
    read_keep_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        rd_hi |=> ($past(stick[13:7] & cond_q[13:7])
        & ~stick[13:7]) == 7'h00)
        else $error("persistent fault cleared by read");
    summary_read_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        rd_lo_s |-> reg_rdata_o[`LSAL_BIT_SUMMARY]
        == $past(|st_hi))
        else $error("summary bit not showing second register");
    alert_on_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        unmasked_s |-> alert_oe_o)
        else $error("alert released with unmasked flag");
    masked_quiet_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        quiet_s |-> !alert_oe_o)
        else $error("alert asserted by masked source only");
endmodule

//--- lsal_meas_src.sv
`timescale 1ns/100ps
// ****************************************
// measurement source behind the sequencer
// ****************************************
module lsal_meas_src (
    input wire logic clock_i, // system clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic meas_req_i, // request from the design
    input wire logic [3:0] meas_chan_i, // channel asked for
    input wire logic start_i, // grant one round of answers
    input wire logic slow_i, // answer after a few cycles
    input wire logic [13:0][15:0] vals_i, // value per channel
    output lsal_pkg::lsal_meas_t meas_o, // result back
    output logic done_o // round fully answered
);
    logic pend_q; // request outstanding
    logic [3:0] chan_q; // its channel
    logic [2:0] wait_q; // cycles left before answer
    logic [4:0] budget_q; // answers left in this round
    logic [15:0] last_q; // last value handed out
    assign done_o = (budget_q == 5'd0);
    // answers are withheld once the budget is spent, so the
    // design parks in its wait state while the host reads
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_q <= 1'b0;
            chan_q <= 4'h0;
            wait_q <= 3'h0;
            budget_q <= 5'h00;
            last_q <= 16'h0000;
            meas_o <= '0;
        end else begin
            meas_o.valid <= 1'b0;
            // data line never holds a stale value between results
            meas_o.value <= ~last_q;
            if (start_i) begin
                budget_q <= 5'd14;
            end
            if (meas_req_i) begin
                pend_q <= 1'b1;
                chan_q <= meas_chan_i;
                wait_q <= slow_i ? 3'd5 : 3'd0;
            end else if (pend_q && budget_q != 5'd0) begin
                if (wait_q != 3'd0) begin
                    wait_q <= wait_q - 3'd1;
                end else begin
                    pend_q <= 1'b0;
                    budget_q <= budget_q - 5'd1;
                    meas_o.valid <= 1'b1;
                    meas_o.value <= vals_i[chan_q];
                    last_q <= vals_i[chan_q];
                end
            end
        end
    end
endmodule

//--- tb.sv
`timescale 1ns/100ps
// ****************************************
// self-checking bench for the alert logic
// ****************************************
module tb;
    localparam logic [7:0] T_LO = 8'hf6; // temp low limit, -10
    localparam logic [7:0] T_HI = 8'h32; // temp high limit, +50
    localparam logic [15:0] F_MIN = 16'h1000; // slowest tach period
    localparam logic [15:0] F_MAX = 16'h0100; // fastest tach period
    logic clock_i = 1'b0; // system clock
    logic rst_n_i = 1'b0; // reset, active low
    lsal_pkg::lsal_reg_req_t req = '0; // register access
    lsal_pkg::lsal_meas_t meas; // result from partner
    logic [7:0] reg_rdata_o; // read data
    logic meas_req_o, monitor_go_o, alert_o, alert_oe_o; // outputs
    logic [3:0] meas_chan_o; // channel asked for
    logic below = 1'b0, start = 1'b0, slow = 1'b0, done; // partner ctl
    logic [13:0][15:0] vals = '0; // values for the round
    logic [13:0] stk = '0, cond = '0; // model sticky, latest fault
    logic below_s = 1'b0, go_x = 1'b0; // model below flag, go bit
    logic [7:0] mlo = '0, mhi = '0, d; // model masks, read byte
    logic [3:0] exp_chan = 4'h0; // next channel in the rotation
    logic [7:0] ra [9] = '{8'h41, 8'h42, 8'h72, 8'h73, 8'h44, 8'h45,
        8'h58, 8'h60, 8'h30}; // reset probes, last one unmapped
    logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h81, 8'h7f,
        8'hff, 8'h00, 8'h00}; // their expected values
    int err_total = 0, samples_checked = 0;
    always #4 clock_i = ~clock_i; // 125 MHz
    lsal_top i_lsal_top (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .reg_req_i(req), .reg_rdata_o(reg_rdata_o),
        .meas_req_o(meas_req_o), .meas_chan_o(meas_chan_o),
        .meas_i(meas), .below_tmin_i(below),
        .monitor_go_o(monitor_go_o), .alert_o(alert_o),
        .alert_oe_o(alert_oe_o));
    lsal_meas_src i_lsal_meas_src (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .meas_req_i(meas_req_o), .meas_chan_i(meas_chan_o),
        .start_i(start), .slow_i(slow), .vals_i(vals), .meas_o(meas),
        .done_o(done));
    // ****************************************
    // expectations
    // ****************************************
    function automatic logic fault(int ch, logic [15:0] v);
        if (ch < 10) begin
            return ($signed(v[7:0]) > $signed(T_HI)) ||
                ($signed(v[7:0]) <= $signed(T_LO));
        end
        return (v > F_MIN) || (v < F_MAX); // long period is slow
    endfunction
    function automatic logic [7:0] exp_hi();
        return {stk[13:10], below_s, stk[9:7]};
    endfunction
    function automatic logic [7:0] exp_lo();
        return {|exp_hi(), stk[6:0]};
    endfunction
    // below flag and summary never take part
    function automatic logic exp_alert();
        return |(stk[6:0] & ~mlo[6:0]) | |(stk[9:7] & ~mhi[2:0]) |
            |(stk[13:10] & ~mhi[7:4]);
    endfunction
    // boundary values mostly, one random pick in five
    function automatic logic [15:0] pick(int ch);
        logic [7:0] t [5];
        logic [15:0] f [5];
        t = '{T_LO, T_HI, T_HI + 8'h01, T_LO + 8'h01, 8'($urandom)};
        f = '{F_MIN, F_MIN + 16'h1, F_MAX, F_MAX - 16'h1, 16'($urandom)};
        return (ch < 10) ? {8'h00, t[$urandom_range(0, 4)]} :
            f[$urandom_range(0, 4)];
    endfunction
    // ****************************************
    // compare, bus and closing tasks
    // ****************************************
    task automatic chk_byte(string n, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(string n, logic e, logic g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic results();
        if (err_total == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic reg_wr(logic [7:0] a, logic [7:0] v);
        @(posedge clock_i);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= v;
        @(posedge clock_i);
        req.wr <= 1'b0;
    endtask
    // data lands on the edge that takes the strobe
    task automatic reg_rd(logic [7:0] a, output logic [7:0] v);
        @(posedge clock_i);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clock_i);
        req.rd <= 1'b0;
        #1 v = reg_rdata_o;
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 2000) begin
            @(posedge clock_i);
            n++;
        end
        if (n >= 2000) begin
            err_total++;
            results();
        end
    endtask
    // rotation order watched on every request
    always @(posedge clock_i) begin
        if (rst_n_i && meas_req_o) begin
            chk_byte("meas_chan", {4'h0, exp_chan}, {4'h0, meas_chan_o});
            chk_bit("req_with_go", 1'b1, go_x);
        end
        if (rst_n_i && meas.valid) begin
            exp_chan <= (exp_chan == 4'd13) ? 4'd0 : exp_chan + 4'd1;
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h9867));
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        chk_bit("alert_rst", 1'b0, alert_oe_o);
        for (int i = 0; i < 9; i++) begin
            reg_rd(ra[i], d);
            chk_byte("reset_value", rv[i], d);
        end
        // unused mask bits must read back zero
        reg_wr(8'h72, 8'hff);
        reg_rd(8'h72, d);
        chk_byte("mask_low", 8'h7f, d);
        reg_wr(8'h73, 8'hff);
        reg_rd(8'h73, d);
        chk_byte("mask_high", 8'hf7, d);
        // limits go in before monitoring starts
        for (int k = 0; k < 10; k++) begin
            reg_wr(8'h44 + 8'(2 * k), T_LO);
            reg_wr(8'h45 + 8'(2 * k), T_HI);
        end
        for (int k = 0; k < 4; k++) begin
            reg_wr(8'h58 + 8'(2 * k), F_MIN[7:0]);
            reg_wr(8'h59 + 8'(2 * k), F_MIN[15:8]);
            reg_wr(8'h60 + 8'(2 * k), F_MAX[7:0]);
            reg_wr(8'h61 + 8'(2 * k), F_MAX[15:8]);
        end
        repeat (20) @(posedge clock_i);
        chk_bit("monitor_idle", 1'b0, monitor_go_o);
        reg_wr(8'h40, 8'h01);
        go_x = 1'b1;
        #1 chk_bit("monitor_go", 1'b1, monitor_go_o);
        for (int r = 0; r < 12; r++) begin
            mlo = 8'($urandom) & 8'h7f;
            mhi = 8'($urandom) & 8'hf7;
            reg_wr(8'h72, mlo | 8'h80);
            reg_wr(8'h73, mhi | 8'h08);
            if (r == 5) begin
                // stop and restart mid-wait, rotation must resume
                reg_wr(8'h40, 8'h00);
                go_x = 1'b0;
                repeat (20) @(posedge clock_i);
                reg_wr(8'h40, 8'h01);
                go_x = 1'b1;
            end
            @(posedge clock_i);
            for (int c = 0; c < 14; c++) begin
                vals[c] <= pick(c);
            end
            below <= 1'($urandom);
            slow <= 1'($urandom);
            start <= 1'b1;
            @(posedge clock_i);
            start <= 1'b0;
            @(posedge clock_i);
            wait_done();
            repeat (3) @(posedge clock_i);
            below_s = below_s | below;
            below <= 1'b0;
            for (int c = 0; c < 14; c++) begin
                cond[c] = fault(c, vals[c]);
                stk[c] = stk[c] | cond[c];
            end
            chk_bit("alert", exp_alert(), alert_oe_o);
            chk_bit("alert_level", 1'b0, alert_o);
            reg_rd(8'h41, d);
            chk_byte("status_low", exp_lo(), d);
            stk[6:0] = stk[6:0] & cond[6:0];
            reg_rd(8'h41, d);
            chk_byte("status_low_again", exp_lo(), d);
            if (d[7] === 1'b1) begin
                reg_rd(8'h42, d);
                chk_byte("status_high", exp_hi(), d);
                stk[13:7] = stk[13:7] & cond[13:7];
                below_s = 1'b0;
            end
            repeat (2) @(posedge clock_i);
            chk_bit("alert_after_read", exp_alert(), alert_oe_o);
        end
        results();
    end
endmodule
